// >>> epo_pkg.sv
// Package of constants and types for the energy pulse output and sag detect block
`default_nettype none
package epo_pkg;
   // ---------------------------------------------------------------
   // Widths and scaling
   // ---------------------------------------------------------------
   localparam int DATA_W = 24;                 // Normalised signed sample width
   localparam int RATE_W = 24;                 // Pulse-rate setting, fraction of full scale
   localparam int PW_W = 16;                   // Pulse duration setting width
   localparam int DUR_W = 24;                  // Dip duration width
   localparam int MAX_PULSE_DIV = 2048;        // Pulse period floor in divided clocks
   localparam int OWR_DIV = 1024;              // Divided clocks per output word
   localparam int PW_UNIT = 1024;              // Divided clocks per pulse-width unit
   localparam int ACC_W = 50;                  // Energy accumulator width
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] THIRD_MODE_RST = 2'h0;
   localparam logic SECOND_MODE_RST = 1'h0;
   // ---------------------------------------------------------------
   // Third pin modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EPO_E3_REACTIVE = 2'h0,
      EPO_E3_SUPPLY = 2'h1,
      EPO_E3_VSIGN = 2'h2,
      EPO_E3_APPARENT = 2'h3
   } epo_e3_mode_type;
endpackage
`default_nettype wire

// >>> epo_pulse_if.sv
// Interface carrying one energy channel between top and pulse generator
`default_nettype none
interface epo_pulse_if;
   logic signed [epo_pkg::DATA_W-1:0] power;
   logic enable;
   logic pulse_n;
   logic negative;
   modport top (output power, output enable, input pulse_n, input negative);
   modport gen (input power, input enable, output pulse_n, output negative);
endinterface
`default_nettype wire

// >>> epo_pulse_gen.sv
// Energy to pulse converter for one channel
`default_nettype none
module epo_pulse_gen (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Timing enables and settings
   input wire logic word_tick,
   input wire logic div_tick,
   input wire logic [epo_pkg::RATE_W-1:0] pulse_rate_setting,
   input wire logic [epo_pkg::PW_W-1:0] pulse_duration_setting,
   // Channel
   epo_pulse_if.gen ch
);
   logic signed [epo_pkg::ACC_W-1:0] acc_q, acc_d;
   logic [25:0] wid_q;       // Remaining low time in divided clocks
   logic [11:0] gap_q;       // Divided clocks to the minimum period
   logic neg_q;
   logic [epo_pkg::ACC_W-1:0] quantum;
   logic signed [epo_pkg::ACC_W-1:0] step;
   logic fire_pos, fire_neg, ready;

   // Quantum of 2^48 / rate: a full-scale word is rate / 2^25 of a pulse, so rate x word rate / 2
   assign quantum = (epo_pkg::ACC_W'(50'h1) << 48) / epo_pkg::ACC_W'({1'b0, pulse_rate_setting} | 25'h1);
   assign step = ch.enable ? epo_pkg::ACC_W'(ch.power) : '0;
   assign acc_d = acc_q + step;
   // Pulses start only on a divided clock once gap_q has run out, so the period never drops under 2048 divided clocks
   assign ready = (gap_q == 12'h0) && div_tick;
   assign fire_pos = ready && acc_q >= $signed(quantum);
   assign fire_neg = ready && acc_q <= -$signed(quantum);
   assign ch.pulse_n = (wid_q == 26'h0);
   assign ch.negative = neg_q;

   // Accumulate and emit a pulse per quantum of energy
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         acc_q <= '0;
         wid_q <= '0;
         gap_q <= '0;
         neg_q <= 1'b0;
      end else begin
         if (word_tick)
            acc_q <= acc_d;
         else if (fire_pos)
            acc_q <= acc_q - $signed(quantum);
         else if (fire_neg)
            acc_q <= acc_q + $signed(quantum);
         if ((fire_pos || fire_neg) && !word_tick) begin
            neg_q <= fire_neg;
            wid_q <= {pulse_duration_setting, 10'h0} | 26'h1;
            gap_q <= 12'(epo_pkg::MAX_PULSE_DIV - 1);
         end else if (div_tick) begin
            if (wid_q != 26'h0)
               wid_q <= wid_q - 26'h1;
            if (gap_q != 12'h0)
               gap_q <= gap_q - 12'h1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> epo_top.sv
// Energy pulse outputs, pin modes, no-load gating and sag/fault detection
`default_nettype none
module epo_top #(
   parameter int CLK_DIV = 30               // System clocks per divided master clock
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Computed power and samples, one word per output word period
   input wire logic word_valid,
   input wire logic signed [epo_pkg::DATA_W-1:0] active_power,
   input wire logic signed [epo_pkg::DATA_W-1:0] reactive_power,
   input wire logic [epo_pkg::DATA_W-1:0] apparent_power,
   input wire logic signed [epo_pkg::DATA_W-1:0] inst_voltage,
   input wire logic signed [epo_pkg::DATA_W-1:0] inst_current,
   // Supply monitor comparator pin
   input wire logic supply_monitor_comparator,
   // Configuration
   input wire logic second_pin_mode_bit,
   input wire logic [1:0] third_pin_mode_field,
   input wire logic [epo_pkg::RATE_W-1:0] pulse_rate_setting,
   input wire logic [epo_pkg::PW_W-1:0] pulse_duration_setting,
   input wire logic [epo_pkg::DATA_W-1:0] no_load_threshold,
   input wire logic [epo_pkg::DATA_W-1:0] voltage_dip_level,
   input wire logic [epo_pkg::DUR_W-1:0] voltage_dip_duration,
   input wire logic [epo_pkg::DATA_W-1:0] current_dip_level,
   input wire logic [epo_pkg::DUR_W-1:0] current_dip_duration,
   // Energy pins, active low
   output logic active_energy_pulse_pin_n,
   output logic second_energy_pin_n,
   output logic third_energy_pin_n,
   // Status
   output logic voltage_sag_flag,
   output logic current_fault_flag
);
   // ---------------------------------------------------------------
   // Divided clock enable
   // ---------------------------------------------------------------
   logic [15:0] div_cnt_q;
   logic div_tick;
   assign div_tick = (div_cnt_q == 16'(CLK_DIV - 1));

   // Divided master clock enable
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         div_cnt_q <= 16'h0;
      else
         div_cnt_q <= div_tick ? 16'h0 : div_cnt_q + 16'h1;
   end

   // ---------------------------------------------------------------
   // Supply monitor synchroniser
   // ---------------------------------------------------------------
   logic mon_s1_q, mon_s2_q;

   // Two-stage synchroniser for the comparator pin
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mon_s1_q <= 1'b0;
         mon_s2_q <= 1'b0;
      end else begin
         mon_s1_q <= supply_monitor_comparator;
         mon_s2_q <= mon_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Captured words
   // ---------------------------------------------------------------
   logic signed [epo_pkg::DATA_W-1:0] p_q, q_q, v_q;
   logic [epo_pkg::DATA_W-1:0] s_q;
   logic word_q;

   // Hold the latest word for the pulse generators
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         p_q <= '0;
         q_q <= '0;
         s_q <= '0;
         v_q <= '0;
         word_q <= 1'b0;
      end else begin
         word_q <= word_valid;
         if (word_valid) begin
            p_q <= active_power;
            q_q <= reactive_power;
            s_q <= apparent_power;
            v_q <= inst_voltage;
         end
      end
   end

   // ---------------------------------------------------------------
   // No-load gate and pulse generators
   // ---------------------------------------------------------------
   logic [epo_pkg::DATA_W-1:0] p_mag;
   logic active_on;
   assign p_mag = p_q[epo_pkg::DATA_W-1] ? epo_pkg::DATA_W'(-p_q) : p_q;
   assign active_on = (p_mag >= no_load_threshold);

   epo_pulse_if act_ch ();
   epo_pulse_if rea_ch ();
   epo_pulse_if app_ch ();

   // Channel inputs; rates
   assign act_ch.power = p_q;
   assign act_ch.enable = active_on;
   assign rea_ch.power = q_q;
   assign rea_ch.enable = 1'b1;
   assign app_ch.power = $signed({1'b0, s_q[epo_pkg::DATA_W-1:1]});
   assign app_ch.enable = 1'b1;

   epo_pulse_gen u_act (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .word_tick(word_q),
      .div_tick(div_tick),
      .pulse_rate_setting(pulse_rate_setting),
      .pulse_duration_setting(pulse_duration_setting),
      .ch(act_ch.gen)
   );
   epo_pulse_gen u_rea (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .word_tick(word_q),
      .div_tick(div_tick),
      .pulse_rate_setting(pulse_rate_setting),
      .pulse_duration_setting(pulse_duration_setting),
      .ch(rea_ch.gen)
   );
   epo_pulse_gen u_app (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .word_tick(word_q),
      .div_tick(div_tick),
      .pulse_rate_setting(pulse_rate_setting),
      .pulse_duration_setting(pulse_duration_setting),
      .ch(app_ch.gen)
   );

   // ---------------------------------------------------------------
   // Pin selection
   // ---------------------------------------------------------------
   logic sign_level, second_d, third_d;
   epo_pkg::epo_e3_mode_type third_mode;
   assign third_mode = epo_pkg::epo_e3_mode_type'(third_pin_mode_field);
   // Sign follows the last active pulse, or reactive one when active idle
   assign sign_level = !(act_ch.pulse_n ? rea_ch.negative : act_ch.negative);
   assign second_d = second_pin_mode_bit ? app_ch.pulse_n : sign_level;

   // Third pin mode mux
   always_comb begin
      unique case (third_mode)
         epo_pkg::EPO_E3_REACTIVE: third_d = rea_ch.pulse_n;
         epo_pkg::EPO_E3_SUPPLY: third_d = mon_s2_q;
         epo_pkg::EPO_E3_VSIGN: third_d = !v_q[epo_pkg::DATA_W-1];
         epo_pkg::EPO_E3_APPARENT: third_d = app_ch.pulse_n;
      endcase
   end

   // Registered pins
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         active_energy_pulse_pin_n <= 1'b1;
         second_energy_pin_n <= 1'b1;
         third_energy_pin_n <= 1'b1;
      end else begin
         active_energy_pulse_pin_n <= act_ch.pulse_n;
         second_energy_pin_n <= second_d;
         third_energy_pin_n <= third_d;
      end
   end

   // ---------------------------------------------------------------
   // Sag and fault detection, two channels
   // ---------------------------------------------------------------
   logic [epo_pkg::DATA_W-1:0] dip_level [2];
   logic [epo_pkg::DUR_W-1:0] dip_dur [2];
   logic signed [epo_pkg::DATA_W-1:0] dip_sample [2];
   logic [1:0] dip_flag;
   assign dip_level[0] = voltage_dip_level;
   assign dip_level[1] = current_dip_level;
   assign dip_dur[0] = voltage_dip_duration;
   assign dip_dur[1] = current_dip_duration;
   assign dip_sample[0] = inst_voltage;
   assign dip_sample[1] = inst_current;
   assign voltage_sag_flag = dip_flag[0];
   assign current_fault_flag = dip_flag[1];

   for (genvar c = 0; c < 2; c++) begin : g_dip
      logic [epo_pkg::DUR_W-1:0] win_q, low_q;
      logic [epo_pkg::DATA_W-1:0] avg_q, mag;
      logic flag_q, armed, below, win_end;
      assign mag = dip_sample[c][epo_pkg::DATA_W-1] ? epo_pkg::DATA_W'(-dip_sample[c]) : dip_sample[c];
      assign armed = (dip_level[c] != '0) && (dip_dur[c] != '0);
      assign below = (avg_q < dip_level[c]);
      assign win_end = (win_q + epo_pkg::DUR_W'(1) >= dip_dur[c]);
      assign dip_flag[c] = flag_q;

      // Windowed count of below-level samples
      always_ff @(posedge sys_clk) begin
         if (sys_rst || !armed) begin
            win_q <= '0;
            low_q <= '0;
            avg_q <= '0;
            flag_q <= 1'b0;
         end else if (word_valid) begin
            avg_q <= epo_pkg::DATA_W'((25'(avg_q) + 25'(mag)) >> 1);
            if (win_end) begin
               // Strictly more than half the window
               flag_q <= ({low_q + epo_pkg::DUR_W'(below), 1'b0} > {1'b0, dip_dur[c]});
               win_q <= '0;
               low_q <= '0;
            end else begin
               win_q <= win_q + epo_pkg::DUR_W'(1);
               low_q <= low_q + epo_pkg::DUR_W'(below);
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> epo_props.sv
// Concurrent checks on the energy pulse block ports
`default_nettype none
module epo_props #(
   parameter int CLK_DIV = 30
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Inputs watched
   input wire logic word_valid,
   input wire logic signed [epo_pkg::DATA_W-1:0] active_power,
   input wire logic signed [epo_pkg::DATA_W-1:0] inst_voltage,
   input wire logic supply_monitor_comparator,
   input wire logic second_pin_mode_bit,
   input wire logic [1:0] third_pin_mode_field,
   input wire logic [epo_pkg::PW_W-1:0] pulse_duration_setting,
   input wire logic [epo_pkg::DATA_W-1:0] voltage_dip_level,
   input wire logic [epo_pkg::DUR_W-1:0] voltage_dip_duration,
   input wire logic [epo_pkg::DATA_W-1:0] current_dip_level,
   input wire logic [epo_pkg::DUR_W-1:0] current_dip_duration,
   // Outputs watched
   input wire logic active_energy_pulse_pin_n,
   input wire logic second_energy_pin_n,
   input wire logic third_energy_pin_n,
   input wire logic voltage_sag_flag,
   input wire logic current_fault_flag
);
   localparam int MIN_GAP = epo_pkg::MAX_PULSE_DIV * CLK_DIV;
   logic [31:0] gap_q;
   logic [31:0] low_q;
   logic neg_q;
   logic seen_q;
   // Expected low time of one pulse, a zero setting gives a single divided clock
   wire [31:0] pw_w = (pulse_duration_setting == 16'h0 ? 32'h1 : 32'(pulse_duration_setting) * 32'(epo_pkg::PW_UNIT))
      * 32'(CLK_DIV);
   // Cycles since the last active fall, cycles held low, sign of the last non-zero word
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         gap_q <= 32'h0000FFFF;
         low_q <= 32'h0;
         neg_q <= 1'h0;
         seen_q <= 1'h0;
      end else begin
         gap_q <= $fell(active_energy_pulse_pin_n) ? 32'h1 : gap_q + 32'h1;
         low_q <= active_energy_pulse_pin_n ? 32'h0 : low_q + 32'h1;
         if (word_valid && active_power != 24'h0) neg_q <= active_power[23];
         if (word_valid) seen_q <= 1'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   reset_idle_a: assert property ($fell(sys_rst) |-> active_energy_pulse_pin_n && second_energy_pin_n
      && third_energy_pin_n && !voltage_sag_flag && !current_fault_flag) else $error("outputs busy after reset");
   pulse_gap_a: assert property ($fell(active_energy_pulse_pin_n) |-> gap_q >= MIN_GAP)
      else $error("active pulses too close");
   pulse_width_a: assert property ($rose(active_energy_pulse_pin_n) |->
      low_q + CLK_DIV >= pw_w && low_q <= pw_w + CLK_DIV) else $error("active pulse width off");
   active_sign_a: assert property ($fell(active_energy_pulse_pin_n) && !second_pin_mode_bit |->
      second_energy_pin_n == !neg_q) else $error("sign pin wrong at active pulse");
   supply_mode_a: assert property ((third_pin_mode_field == 2'h1 && $stable(supply_monitor_comparator)) [*6]
      |-> third_energy_pin_n == supply_monitor_comparator) else $error("third pin not following monitor");
   volt_sign_a: assert property (
      (seen_q && third_pin_mode_field == 2'h2 && inst_voltage != 24'h0 && $stable(inst_voltage)) [*6]
      |-> third_energy_pin_n == !inst_voltage[23]) else $error("third pin not voltage sign");
   sag_enable_a: assert property ($rose(voltage_sag_flag) |->
      voltage_dip_level != 24'h0 && voltage_dip_duration != 24'h0) else $error("sag flag while disabled");
   fault_enable_a: assert property ($rose(current_fault_flag) |->
      current_dip_level != 24'h0 && current_dip_duration != 24'h0) else $error("fault flag while disabled");
   // Main scenarios reached
   cover property ($fell(active_energy_pulse_pin_n) && !second_energy_pin_n);
   cover property ($fell(third_energy_pin_n) && third_pin_mode_field == 2'h0);
   cover property ($rose(voltage_sag_flag));
endmodule
bind epo_top epo_props #(.CLK_DIV(CLK_DIV)) i_props (.sys_clk, .sys_rst, .word_valid, .active_power, .inst_voltage,
   .supply_monitor_comparator, .second_pin_mode_bit, .third_pin_mode_field, .pulse_duration_setting,
   .voltage_dip_level, .voltage_dip_duration, .current_dip_level, .current_dip_duration,
   .active_energy_pulse_pin_n, .second_energy_pin_n, .third_energy_pin_n, .voltage_sag_flag, .current_fault_flag);
`default_nettype wire

// >>> epo_meter_model.sv
// Pulse counter model standing at the three energy pins
`default_nettype none
module epo_meter_model (
   // Clock and count clear
   input wire logic sys_clk,
   input wire logic clear,
   // Energy pins, active low
   input wire logic active_energy_pulse_pin_n,
   input wire logic second_energy_pin_n,
   input wire logic third_energy_pin_n,
   // Falls on each pin, and those seen with the sign pin low
   output int n_act,
   output int n_act_neg,
   output int n_sec,
   output int n_thr,
   output int n_thr_neg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act_q = 1'h1;
   logic sec_q = 1'h1;
   logic thr_q = 1'h1;
   // Counts falling edges and samples the sign pin at each one
   always @(posedge sys_clk) begin
      act_q <= active_energy_pulse_pin_n;
      sec_q <= second_energy_pin_n;
      thr_q <= third_energy_pin_n;
      if (clear) begin
         {n_act, n_act_neg, n_sec, n_thr, n_thr_neg} <= 160'h0;
      end else begin
         n_act <= n_act + int'(act_q && !active_energy_pulse_pin_n);
         n_act_neg <= n_act_neg + int'(act_q && !active_energy_pulse_pin_n && !second_energy_pin_n);
         n_sec <= n_sec + int'(sec_q && !second_energy_pin_n);
         n_thr <= n_thr + int'(thr_q && !third_energy_pin_n);
         n_thr_neg <= n_thr_neg + int'(thr_q && !third_energy_pin_n && !second_energy_pin_n);
      end
   end
endmodule
`default_nettype wire

// >>> energy_pulse_output_and_sag_detect_tb.sv
// Self-checking bench for the energy pulse block
`default_nettype none
module energy_pulse_output_and_sag_detect_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NW = 1024;
   localparam int WS = 12;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic word_valid = 1'h0;
   logic supply_monitor_comparator = 1'h0;
   logic second_pin_mode_bit = 1'h0;
   logic clear = 1'h1;
   logic [1:0] third_pin_mode_field = 2'h1;
   logic [epo_pkg::PW_W-1:0] pulse_duration_setting = 16'h1;
   logic signed [epo_pkg::DATA_W-1:0] active_power, reactive_power, inst_voltage, inst_current;
   logic [epo_pkg::DATA_W-1:0] apparent_power, no_load_threshold, voltage_dip_level, current_dip_level;
   logic [epo_pkg::DUR_W-1:0] voltage_dip_duration, current_dip_duration;
   logic [epo_pkg::RATE_W-1:0] pulse_rate_setting;
   logic active_energy_pulse_pin_n, second_energy_pin_n, third_energy_pin_n, voltage_sag_flag, current_fault_flag;
   int n_act, n_act_neg, n_sec, n_thr, n_thr_neg;
   int n_fail = 0;
   int checks_done = 0;
   int seed = 49;
   always #4 sys_clk = ~sys_clk;
   epo_top #(.CLK_DIV(1)) i_dut (.sys_clk, .sys_rst, .word_valid, .active_power, .reactive_power, .apparent_power,
      .inst_voltage, .inst_current, .supply_monitor_comparator, .second_pin_mode_bit, .third_pin_mode_field,
      .pulse_rate_setting, .pulse_duration_setting, .no_load_threshold, .voltage_dip_level, .voltage_dip_duration,
      .current_dip_level, .current_dip_duration, .active_energy_pulse_pin_n, .second_energy_pin_n,
      .third_energy_pin_n, .voltage_sag_flag, .current_fault_flag);
   epo_meter_model i_meter (.sys_clk, .clear, .active_energy_pulse_pin_n, .second_energy_pin_n,
      .third_energy_pin_n, .n_act, .n_act_neg, .n_sec, .n_thr, .n_thr_neg);
   // Verdict and end of run
   task automatic give_verdict();
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Count compare against a range
   task automatic chk_range(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("wrong value at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // Flag compare
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   // Pulses from full-scale input: half the rate fraction per word, capped by the pulse gap
   function automatic int n_exp(input longint rate, input int words);
      longint e;
      e = (rate * words) >> 25;
      return (e < words * WS / 2048) ? int'(e) : words * WS / 2048;
   endfunction
   // Range check around the expected pulse count, allowing carry-over at phase edges
   task automatic chk_rate(input int got, input longint rate, input int words);
      chk_range(got, n_exp(rate, words) - 2, n_exp(rate, words) + 1);
   endtask
   // Random sample, small (under 2^18) or large (at least 2^22), random sign
   function automatic logic signed [epo_pkg::DATA_W-1:0] samp(input logic big);
      logic [epo_pkg::DATA_W-1:0] v;
      v = 24'($random(seed));
      v = big ? {2'h1, v[21:0]} : {6'h0, v[17:0]};
      return v[0] ? -v : v;
   endfunction
   // Clears the counter, then sends words at a fixed spacing with random samples
   task automatic run_phase(input int words, input logic vbig, input logic ibig, input logic rnd);
      clear = 1'h1;
      @(negedge sys_clk);
      clear = 1'h0;
      for (int w = 0; w < words; w++) begin
         word_valid = 1'h1;
         supply_monitor_comparator = 1'($random(seed));
         inst_voltage = samp(vbig);
         inst_current = samp(ibig);
         if (rnd) active_power = 24'($random(seed)) & 24'h3FFFFF;
         @(negedge sys_clk);
         word_valid = 1'h0;
         repeat (WS - 1) @(negedge sys_clk);
      end
   endtask
   // Watchdog well past the expected run length
   initial begin
      #720000;
      n_fail++;
      give_verdict();
   end
   // Main sequence
   initial begin
      {reactive_power, apparent_power, inst_voltage, inst_current, no_load_threshold} = 120'h0;
      voltage_dip_level = 24'h100000;
      current_dip_level = 24'h100000;
      voltage_dip_duration = 24'h20;
      current_dip_duration = 24'h20;
      pulse_rate_setting = 24'h020000;
      active_power = 24'h7FFFFF;
      repeat (16) @(negedge sys_clk);
      sys_rst = 1'h0;
      run_phase(NW, 1'h0, 1'h1, 1'h0);
      chk_rate(n_act, 24'h020000, NW);
      chk_range(n_act_neg, 0, 0);
      chk_bit(voltage_sag_flag, 1'h1);
      chk_bit(current_fault_flag, 1'h0);
      third_pin_mode_field = 2'h2;
      pulse_rate_setting = 24'hFFFFFF;
      active_power = 24'h800001;
      run_phase(NW, 1'h1, 1'h0, 1'h0);
      chk_rate(n_act, 24'hFFFFFF, NW);
      chk_range(n_act_neg, n_act, n_act);
      chk_bit(voltage_sag_flag, 1'h0);
      chk_bit(current_fault_flag, 1'h1);
      third_pin_mode_field = 2'h0;
      pulse_rate_setting = 24'h020000;
      active_power = 24'h0;
      reactive_power = 24'h800001;
      run_phase(NW, 1'h1, 1'h1, 1'h0);
      chk_rate(n_thr, 24'h020000, NW);
      chk_range(n_thr_neg, n_thr, n_thr);
      second_pin_mode_bit = 1'h1;
      third_pin_mode_field = 2'h3;
      reactive_power = 24'h0;
      apparent_power = 24'hFFFFFF;
      run_phase(NW, 1'h1, 1'h1, 1'h0);
      chk_rate(n_sec, 24'h020000, NW);
      chk_rate(n_thr, 24'h020000, NW);
      sys_rst = 1'h1;
      second_pin_mode_bit = 1'h0;
      third_pin_mode_field = 2'h2;
      apparent_power = 24'h0;
      voltage_dip_duration = 24'h0;
      current_dip_duration = 24'h0;
      pulse_rate_setting = 24'hFFFFFF;
      no_load_threshold = 24'h400000;
      repeat (16) @(negedge sys_clk);
      sys_rst = 1'h0;
      run_phase(256, 1'h0, 1'h0, 1'h1);
      chk_range(n_act, 0, 0);
      chk_bit(voltage_sag_flag, 1'h0);
      chk_bit(current_fault_flag, 1'h0);
      no_load_threshold = 24'h0;
      run_phase(256, 1'h0, 1'h0, 1'h1);
      chk_range(n_act, 1, 3);
      give_verdict();
   end
endmodule
`default_nettype wire
